/* pkg/brf_consts.svh */
// Purpose: Constants for the banked register file address decoder
// Assumes: 8-bit register addresses, 256-byte physical file per page
// Notes: Operation list follows
// Operation
// - Direct addresses D0H-FFH select the upper system region; direct C0H-CFH is a working reference.
// - E0H-FFH split into two 32-byte banks chosen by bank instructions.
// - Reset selects bank zero.
// - System registers at D0H-DFH, common scratch at C0H-CFH.
// - Upper region reachable directly regardless of page.
// - Common scratch area reached only by working-register addressing.
// - Duplicate 64-byte upper area; pages 0-1 large, page 0 small variant.
// - Indirect or indexed C0H-FFH goes to duplicate area; direct to system.
// - Direct addressing reaches everything except the duplicate area.
// - 00H-BFH of each page is prime area, all modes.
// - Page 0 prime after reset; other pages via page pointer.
// - File seen as 32 slices of eight registers sharing five upper bits.
// - Two independent slice pointers form a sixteen-byte working block.
// - Working-register accesses never reach the duplicate area.
// - Slice pointers sit at D6H and D7H.
// - Reset: first pointer C0H, second pointer C8H.
// - Pointers set by set instructions or load; combined sets op and op+8.
// - Register pairs use even address for MSB, odd address for LSB.
// - Common working area reachable from any page.
// - 4-bit address: top bit picks pointer, pointer[7:3] joins addr[2:0].
// - 8-bit address with upper nibble 1100B is a working reference.
// - Page pointer at DFH: low nibble source, high destination, reset 0; decode uses only the low nibble, for reads and writes alike.
`ifndef BRF_CONSTS_SVH
`define BRF_CONSTS_SVH
`define BRF_UPPER_BASE 8'hc0
`define BRF_BANK_BASE 8'he0
`define BRF_SYS_BASE 8'hd0
`define BRF_PRIME_TOP 8'hbf
`define BRF_WORK_NIBBLE 4'hc
`define BRF_SLICE_A_ADDR 8'hd6
`define BRF_SLICE_B_ADDR 8'hd7
`define BRF_PAGE_ADDR 8'hdf
`define BRF_SLICE_A_RESET 8'hc0
`define BRF_SLICE_B_RESET 8'hc8
`define BRF_PAGE_RESET 8'h00
`define BRF_SLICE_STEP 8'h08
`define BRF_LARGE_PAGES 4'h1
`define BRF_SMALL_PAGES 4'h0
`endif

/* pkg/brf_pkg.sv */
// Purpose: Types for the banked register file address decoder
// Assumes: Constants come from brf_consts.svh
// Notes: Region codes are one-hot
package brf_pkg;
	// Addressing mode of an access
	typedef enum logic [2:0] {
		BRF_MODE_DIRECT = 3'h0,
		BRF_MODE_INDIRECT = 3'h1,
		BRF_MODE_INDEXED = 3'h2,
		BRF_MODE_WORK4 = 3'h3,
		BRF_MODE_OTHER = 3'h4
	} brf_mode_t;
	// Physical region reached
	typedef enum logic [5:0] {
		BRF_REG_PRIME = 6'h01,
		BRF_REG_SCRATCH = 6'h02,
		BRF_REG_SYSTEM = 6'h04,
		BRF_REG_BANK = 6'h08,
		BRF_REG_DUP = 6'h10,
		BRF_REG_NONE = 6'h20
	} brf_region_t;
	// Access request from the CPU
	typedef struct packed {
		logic valid;
		brf_mode_t mode;
		logic [7:0] addr;
		logic pair;
	} brf_req_t;
	// Decoded physical location
	typedef struct packed {
		logic valid;
		brf_region_t region;
		logic [3:0] page;
		logic bank;
		logic [7:0] addr;
		logic pair_err;
	} brf_loc_t;
	// Pointer update commands
	typedef struct packed {
		logic set_both;
		logic set_first;
		logic set_second;
		logic sel_bank_zero;
		logic sel_bank_one;
		logic [7:0] operand;
	} brf_cmd_t;
endpackage : brf_pkg

/* verilog/brf_work_addr.sv */
// Purpose: Forms an 8-bit register address from a working-register nibble
// Assumes: Pointers come from the same clock domain
// Notes: Purely combinational
`timescale 1ns/1ps
`include "brf_consts.svh"
module brf_work_addr (
	input wire logic [3:0] nib_i,
	input wire logic [7:0] ptr_a_i,
	input wire logic [7:0] ptr_b_i,
	output logic [7:0] addr_o
);
	// Top bit picks the pointer, its five upper bits join the low three
	always_comb begin
		addr_o = nib_i[3] ? {ptr_b_i[7:3], nib_i[2:0]} : {ptr_a_i[7:3], nib_i[2:0]};
	end
endmodule : brf_work_addr

/* verilog/brf_decoder.sv */
// Purpose: Decodes register file accesses into physical regions
// Assumes: Requests and commands come from CPU logic on ref_clk_i
// Notes: Decoding is combinational; pointer state is registered
`timescale 1ns/1ps
`include "brf_consts.svh"
module brf_decoder #(
	parameter logic LARGE_VARIANT = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire brf_pkg::brf_req_t req_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	input wire brf_pkg::brf_cmd_t cmd_i,
	output brf_pkg::brf_loc_t loc_o,
	output logic [7:0] rdata_o,
	output logic rdata_hit_o,
	output logic [7:0] slice_ptr_a_o,
	output logic [7:0] slice_ptr_b_o,
	output logic [7:0] page_ptr_o,
	output logic bank_o
);
	//--------------------------------------------------------------
	// Pointer state
	//--------------------------------------------------------------
	logic [7:0] ptr_a_q;
	logic [7:0] ptr_b_q;
	logic [7:0] page_q;
	logic bank_q;
	logic [7:0] work_addr;
	logic [7:0] eff_addr;
	logic is_work;
	logic dir_wr;

	// Operand plus step, kept in eight bits so the wrap is deliberate
	function automatic logic [7:0] plus_step(input logic [7:0] v);
		plus_step = 8'(v + `BRF_SLICE_STEP);
	endfunction : plus_step

	// Direct write to a pointer register
	function automatic logic dir_hit(input brf_pkg::brf_req_t r, input logic [7:0] a);
		dir_hit = r.valid && r.mode == brf_pkg::BRF_MODE_DIRECT && r.addr == a;
	endfunction : dir_hit

	assign dir_wr = wr_i && req_i.valid;

	// First slice pointer; instructions beat a plain load in the same cycle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_a_q <= `BRF_SLICE_A_RESET;
		end else if (cmd_i.set_both || cmd_i.set_first) begin
			ptr_a_q <= cmd_i.operand;
		end else if (dir_wr && dir_hit(req_i, `BRF_SLICE_A_ADDR)) begin
			ptr_a_q <= wdata_i;
		end
	end

	// Second slice pointer, independent of the first
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_b_q <= `BRF_SLICE_B_RESET;
		end else if (cmd_i.set_both) begin
			ptr_b_q <= plus_step(cmd_i.operand);
		end else if (cmd_i.set_second) begin
			ptr_b_q <= cmd_i.operand;
		end else if (dir_wr && dir_hit(req_i, `BRF_SLICE_B_ADDR)) begin
			ptr_b_q <= wdata_i;
		end
	end

	// Page pointer
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			page_q <= `BRF_PAGE_RESET;
		end else if (dir_wr && dir_hit(req_i, `BRF_PAGE_ADDR)) begin
			page_q <= wdata_i;
		end
	end

	// Bank bit; select-one wins if both arrive together
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bank_q <= 1'b0;
		end else if (cmd_i.sel_bank_one) begin
			bank_q <= 1'b1;
		end else if (cmd_i.sel_bank_zero) begin
			bank_q <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// Address formation
	//--------------------------------------------------------------
	brf_work_addr u_work (
		.nib_i(req_i.addr[3:0]),
		.ptr_a_i(ptr_a_q),
		.ptr_b_i(ptr_b_q),
		.addr_o(work_addr)
	);

	// Working reference: 4-bit mode, or direct address with 1100B nibble
	assign is_work = req_i.mode == brf_pkg::BRF_MODE_WORK4 ||
		(req_i.mode == brf_pkg::BRF_MODE_DIRECT &&
		req_i.addr[7:4] == `BRF_WORK_NIBBLE);
	assign eff_addr = is_work ? work_addr : req_i.addr;

	//--------------------------------------------------------------
	// Region decode
	//--------------------------------------------------------------
	// Upper area chosen by mode; prime area uses the source page
	always_comb begin
		loc_o = '0;
		loc_o.valid = req_i.valid;
		loc_o.addr = eff_addr;
		loc_o.bank = bank_q;
		loc_o.page = 4'h0;
		loc_o.region = brf_pkg::BRF_REG_NONE;
		loc_o.pair_err = req_i.valid && req_i.pair && eff_addr[0];
		if (eff_addr <= `BRF_PRIME_TOP) begin
			loc_o.region = brf_pkg::BRF_REG_PRIME;
			loc_o.page = page_q[3:0];
		end else if (is_work) begin
			// Slice pointers never land in the duplicate area
			if (eff_addr < `BRF_SYS_BASE) begin
				loc_o.region = brf_pkg::BRF_REG_SCRATCH;
			end else if (eff_addr < `BRF_BANK_BASE) begin
				loc_o.region = brf_pkg::BRF_REG_SYSTEM;
			end else begin
				loc_o.region = brf_pkg::BRF_REG_BANK;
			end
		end else begin
			case (req_i.mode)
				brf_pkg::BRF_MODE_DIRECT: begin
					if (eff_addr >= `BRF_BANK_BASE) begin
						loc_o.region = brf_pkg::BRF_REG_BANK;
					end else begin
						loc_o.region = brf_pkg::BRF_REG_SYSTEM;
					end
				end
				brf_pkg::BRF_MODE_INDIRECT,
				brf_pkg::BRF_MODE_INDEXED: begin
					// Duplicate area exists only on pages the variant has
					if (page_q[3:0] <= (LARGE_VARIANT ? `BRF_LARGE_PAGES :
						`BRF_SMALL_PAGES)) begin
						loc_o.region = brf_pkg::BRF_REG_DUP;
						loc_o.page = page_q[3:0];
					end
				end
				default: begin
					loc_o.region = brf_pkg::BRF_REG_NONE;
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// Readback of the decoder's own registers
	//--------------------------------------------------------------
	logic [7:0] rdata_q;
	logic hit_q;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
			hit_q <= 1'b0;
		end else begin
			hit_q <= 1'b0;
			rdata_q <= 8'h00;
			if (req_i.valid && !wr_i && req_i.mode == brf_pkg::BRF_MODE_DIRECT) begin
				case (req_i.addr)
					`BRF_SLICE_A_ADDR: begin
						rdata_q <= ptr_a_q;
						hit_q <= 1'b1;
					end
					`BRF_SLICE_B_ADDR: begin
						rdata_q <= ptr_b_q;
						hit_q <= 1'b1;
					end
					`BRF_PAGE_ADDR: begin
						rdata_q <= page_q;
						hit_q <= 1'b1;
					end
					default: begin
						hit_q <= 1'b0;
					end
				endcase
			end
		end
	end

	assign rdata_o = rdata_q;
	assign rdata_hit_o = hit_q;
	assign slice_ptr_a_o = ptr_a_q;
	assign slice_ptr_b_o = ptr_b_q;
	assign page_ptr_o = page_q;
	assign bank_o = bank_q;

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	sequence s_set_both;
		cmd_i.set_both;
	endsequence
	sequence s_both_loaded;
		ptr_a_q == $past(cmd_i.operand) && ptr_b_q == 8'($past(cmd_i.operand) + 8'h08);
	endsequence

	a_set_both_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_set_both |=> s_both_loaded) else $error("Combined pointer set wrong");
	a_bank_one_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cmd_i.sel_bank_one |=> bank_q) else $error("Bank one not selected");
	a_bank_zero_clr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cmd_i.sel_bank_zero && !cmd_i.sel_bank_one |=> !bank_q)
		else $error("Bank zero not selected");
	a_work_no_dup: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		is_work |-> loc_o.region != brf_pkg::BRF_REG_DUP)
		else $error("Working access reached duplicate area");
	a_direct_no_dup: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		req_i.mode == brf_pkg::BRF_MODE_DIRECT |-> loc_o.region != brf_pkg::BRF_REG_DUP)
		else $error("Direct access reached duplicate area");
	a_indirect_dup: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		req_i.mode == brf_pkg::BRF_MODE_INDIRECT && req_i.addr >= 8'hc0 && page_q == 8'h00
		|-> loc_o.region == brf_pkg::BRF_REG_DUP) else $error("Indirect missed duplicate");
	a_prime_page: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!is_work && req_i.addr <= 8'hbf |-> loc_o.region == brf_pkg::BRF_REG_PRIME &&
		loc_o.page == page_q[3:0]) else $error("Prime area decode wrong");
	a_work_addr_form: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		req_i.mode == brf_pkg::BRF_MODE_WORK4 && !req_i.addr[3] |->
		loc_o.addr == {ptr_a_q[7:3], req_i.addr[2:0]}) else $error("Work address wrong");
	a_work8_form: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		req_i.mode == brf_pkg::BRF_MODE_DIRECT && req_i.addr[7:4] == 4'hc && req_i.addr[3]
		|-> loc_o.addr == {ptr_b_q[7:3], req_i.addr[2:0]}) else $error("8-bit work wrong");
	a_pair_odd: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		req_i.valid && req_i.pair |-> loc_o.pair_err == loc_o.addr[0])
		else $error("Pair alignment flag wrong");
	a_page_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		dir_wr && dir_hit(req_i, 8'hdf) |=> page_q == $past(wdata_i))
		else $error("Page pointer not loaded");
	// Readback flag only follows a direct read of a pointer register
	a_readback_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(req_i.valid && !wr_i && req_i.mode == brf_pkg::BRF_MODE_DIRECT) |=> !hit_q)
		else $error("Readback flag without a read");
	a_loc_valid: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		loc_o.valid == req_i.valid) else $error("Location valid does not follow request");
endmodule : brf_decoder

/* dv/brf_cpu_model.sv */
// Purpose: Stand-in for the CPU operand addressing logic driving the decoder
// Assumes: Requests change only at the falling edge of ref_clk_i
// Notes: Released address lines show the inverse of the last value
`timescale 1ns/1ps
module brf_cpu_model (
	input wire logic ref_clk_i,
	output brf_pkg::brf_req_t req_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	output brf_pkg::brf_cmd_t cmd_o
);
	initial begin
		req_o = '0;
		wr_o = 1'b0;
		wdata_o = 8'h00;
		cmd_o = '0;
	end

	// -----------------------------------------------------------------
	// Access and command tasks
	// -----------------------------------------------------------------
	// Present one access; it stands until idle is called
	task automatic drive(input logic [2:0] m, input logic [7:0] a, input logic p,
		input logic w, input logic [7:0] d);
		@(negedge ref_clk_i);
		req_o = {1'b1, m, a, p};
		wr_o = w;
		wdata_o = d;
	endtask : drive

	// Release the bus; stale lines must not look like the last access
	task automatic idle();
		@(negedge ref_clk_i);
		req_o = {1'b0, req_o.mode, ~req_o.addr, 1'b0};
		wr_o = 1'b0;
		wdata_o = ~wdata_o;
	endtask : idle

	// One-cycle command pulse, as the execution unit issues them
	task automatic pulse(input logic [12:0] c);
		@(negedge ref_clk_i);
		cmd_o = c;
		@(negedge ref_clk_i);
		cmd_o = '0;
	endtask : pulse
endmodule : brf_cpu_model

/* dv/tb.sv */
// Purpose: Self-checking bench for the banked register file decoder
// Assumes: Large variant, pages 0 and 1 back the duplicate area
// Notes: Access and command stimulus goes through the CPU model at the falling edge; reset is driven here
`timescale 1ns/1ps
module tb;
	logic ref_clk_i;
	logic rst_i;
	brf_pkg::brf_req_t req;
	brf_pkg::brf_cmd_t cmd;
	brf_pkg::brf_loc_t loc;
	logic wr;
	logic [7:0] wdata, rdata, ptr_a, ptr_b, page;
	logic hit, bank;
	int errors = 0;
	int num_checks = 0;

	brf_decoder #(.LARGE_VARIANT(1'b1)) brf_decoder_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.req_i(req), .wr_i(wr), .wdata_i(wdata), .cmd_i(cmd), .loc_o(loc), .rdata_o(rdata),
		.rdata_hit_o(hit), .slice_ptr_a_o(ptr_a), .slice_ptr_b_o(ptr_b), .page_ptr_o(page),
		.bank_o(bank));
	brf_cpu_model brf_cpu_model_i (.ref_clk_i(ref_clk_i), .req_o(req), .wr_o(wr),
		.wdata_o(wdata), .cmd_o(cmd));

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Decode is combinational, so look once the inputs settle
	task automatic look(input logic [2:0] m, input logic [7:0] a, input logic p,
		input brf_pkg::brf_region_t r, input logic [7:0] ea);
		brf_cpu_model_i.drive(m, a, p, 1'b0, 8'h00);
		#1;
		chk({2'h0, loc.region}, {2'h0, r});
		chk(loc.addr, ea);
		brf_cpu_model_i.idle();
	endtask : look

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		brf_cpu_model_i.drive(3'h0, a, 1'b0, 1'b1, d);
		brf_cpu_model_i.idle();
	endtask : wr_reg

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#20000;
		errors++;
		give_verdict();
	end

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		chk(ptr_a, 8'hc0);
		chk(ptr_b, 8'hc8);
		chk(page, 8'h00);
		chk({7'h0, bank}, 8'h00);
		rst_i = 1'b0;
		look(3'h0, 8'h10, 1'b0, brf_pkg::BRF_REG_PRIME, 8'h10);
		look(3'h0, 8'hbf, 1'b0, brf_pkg::BRF_REG_PRIME, 8'hbf);
		look(3'h0, 8'hc2, 1'b0, brf_pkg::BRF_REG_SCRATCH, 8'hc2);
		look(3'h0, 8'hca, 1'b0, brf_pkg::BRF_REG_SCRATCH, 8'hca);
		look(3'h0, 8'hd0, 1'b0, brf_pkg::BRF_REG_SYSTEM, 8'hd0);
		look(3'h0, 8'he5, 1'b0, brf_pkg::BRF_REG_BANK, 8'he5);
		look(3'h1, 8'hc5, 1'b0, brf_pkg::BRF_REG_DUP, 8'hc5);
		look(3'h2, 8'hf0, 1'b0, brf_pkg::BRF_REG_DUP, 8'hf0);
		look(3'h4, 8'hc5, 1'b0, brf_pkg::BRF_REG_NONE, 8'hc5);
		look(3'h3, 8'h03, 1'b0, brf_pkg::BRF_REG_SCRATCH, 8'hc3);
		look(3'h3, 8'h0b, 1'b0, brf_pkg::BRF_REG_SCRATCH, 8'hcb);
		// Readback of a pointer arrives one cycle after the direct read
		brf_cpu_model_i.drive(3'h0, 8'hd6, 1'b0, 1'b0, 8'h00);
		brf_cpu_model_i.idle();
		chk(rdata, 8'hc0);
		chk({7'h0, hit}, 8'h01);
		brf_cpu_model_i.idle();
		chk({7'h0, hit}, 8'h00);
		brf_cpu_model_i.pulse({5'h10, 8'h70});
		chk(ptr_a, 8'h70);
		chk(ptr_b, 8'h78);
		look(3'h3, 8'h06, 1'b0, brf_pkg::BRF_REG_PRIME, 8'h76);
		look(3'h3, 8'h0e, 1'b0, brf_pkg::BRF_REG_PRIME, 8'h7e);
		brf_cpu_model_i.pulse({5'h08, 8'ha0});
		brf_cpu_model_i.pulse({5'h04, 8'h48});
		chk(ptr_a, 8'ha0);
		chk(ptr_b, 8'h48);
		wr_reg(8'hd7, 8'hf8);
		chk(ptr_b, 8'hf8);
		// Pointer aimed into the upper range must never land in the duplicate area
		look(3'h3, 8'h09, 1'b0, brf_pkg::BRF_REG_BANK, 8'hf9);
		brf_cpu_model_i.pulse({5'h01, 8'h00});
		chk({7'h0, bank}, 8'h01);
		brf_cpu_model_i.drive(3'h0, 8'he5, 1'b0, 1'b0, 8'h00);
		#1;
		chk({7'h0, loc.bank}, 8'h01);
		chk({7'h0, loc.valid}, 8'h01);
		brf_cpu_model_i.idle();
		brf_cpu_model_i.pulse({5'h02, 8'h00});
		chk({7'h0, bank}, 8'h00);
		wr_reg(8'hdf, 8'h02);
		chk(page, 8'h02);
		brf_cpu_model_i.drive(3'h0, 8'h10, 1'b0, 1'b0, 8'h00);
		#1;
		chk({4'h0, loc.page}, 8'h02);
		brf_cpu_model_i.idle();
		look(3'h0, 8'hd0, 1'b0, brf_pkg::BRF_REG_SYSTEM, 8'hd0);
		look(3'h1, 8'hc5, 1'b0, brf_pkg::BRF_REG_NONE, 8'hc5);
		wr_reg(8'hdf, 8'h01);
		look(3'h1, 8'hc5, 1'b0, brf_pkg::BRF_REG_DUP, 8'hc5);
		// Register pairs: odd first address is flagged, even is clean
		brf_cpu_model_i.drive(3'h0, 8'h11, 1'b1, 1'b0, 8'h00);
		#1;
		chk({7'h0, loc.pair_err}, 8'h01);
		brf_cpu_model_i.drive(3'h0, 8'h10, 1'b1, 1'b0, 8'h00);
		#1;
		chk({7'h0, loc.pair_err}, 8'h00);
		brf_cpu_model_i.idle();
		// Second reset in mid-run restores the common working block
		rst_i = 1'b1;
		repeat (2) @(negedge ref_clk_i);
		chk(ptr_a, 8'hc0);
		chk(ptr_b, 8'hc8);
		chk(page, 8'h00);
		rst_i = 1'b0;
		give_verdict();
	end
endmodule : tb
